// File: core/sbu_regs.svh
// register offsets, field positions and reset values of the serial bus unit
`ifndef SBU_REGS_SVH
`define SBU_REGS_SVH
`define SBU_ADDR_W 8
`define SBU_OFS_CTRL 8'h00
`define SBU_OFS_STAT 8'h04
`define SBU_OFS_DATA 8'h08
`define SBU_OFS_CNT 8'h0C
`define SBU_OFS_LEN 8'h10
`define SBU_CTRL_COMM_EN 0
`define SBU_CTRL_MASTER_REQ 1
`define SBU_CTRL_SLV_TX_EN 2
`define SBU_CTRL_SLV_RX_EN 3
`define SBU_CTRL_W 4
`define SBU_CTRL_RST 4'h0
`define SBU_STAT_RST 8'h00
`define SBU_LEN_RST 8'h20
`define SBU_DATA_RST 8'h00
`define SBU_RESP_OKAY 2'h0
`define SBU_RESP_SLVERR 2'h2
`endif

// File: core/sbu_pkg.sv
// types shared by the serial bus unit files
package sbu_pkg;
  // events from the bit-level protocol engine, one-cycle pulses except levels
  typedef struct packed {
    logic comm_start;
    logic arb_lost;
    logic slave_req;
    logic rx_valid;
    logic [7:0] rx_byte;
    logic rx_par;
    logic data_field;
    logic bcast;
    logic tx_req;
    logic tx_ack;
    logic tx_nack;
    logic end_comm;
    logic end_frame;
  } sbu_lnk_in_t;
  // answers and settings towards the protocol engine
  typedef struct packed {
    logic tx_valid;
    logic [7:0] tx_byte;
    logic rx_ack;
    logic rx_nack;
    logic abort;
    logic comm_en;
    logic master_req;
    logic slave_tx_enable_flag;
    logic slave_rx_en;
    logic [7:0] tel_len;
  } sbu_lnk_out_t;
  // sticky status, bit 7 down to bit 0
  typedef struct packed {
    logic comm_start;
    logic underrun;
    logic parity;
    logic end_frame;
    logic end_comm;
    logic arb_lost;
    logic slave_req;
    logic err;
  } sbu_stat_t;
  typedef enum logic [1:0] {
    SBU_IDLE,
    SBU_RUN,
    SBU_RETRY
  } sbu_state_t;
endpackage

// File: core/sbu_par.sv
// parity check stage for received bytes, one cycle of latency
`timescale 1ns/100ps
module sbu_par #(
  parameter int W = 8,
  parameter bit ODD = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // received byte
  input wire logic in_valid,
  input wire logic [W-1:0] in_byte,
  input wire logic in_par,
  input wire logic in_df,
  input wire logic in_bc,
  // checked byte
  output logic out_valid,
  output logic [W-1:0] out_byte,
  output logic out_perr,
  output logic out_df,
  output logic out_bc
);
  logic [W:0] acc;
  genvar i;
  assign acc[0] = ODD;
  generate
    for (i = 0; i < W; i++) begin : g_par
      assign acc[i+1] = acc[i] ^ in_byte[i];
    end
  endgenerate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      out_perr <= 1'b0;
      out_byte <= '0;
      out_df <= 1'b0;
      out_bc <= 1'b0;
    end else begin
      out_valid <= in_valid;
      out_perr <= in_valid && (acc[W] != in_par);
      out_byte <= in_byte;
      out_df <= in_df;
      out_bc <= in_bc;
    end
  end
endmodule

// File: core/sbu_axil.sv
// axi4-lite slave front end: either order of address and data, one of each
`timescale 1ns/100ps
`include "sbu_regs.svh"
module sbu_axil #(
  parameter int AW = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  output logic wr_en,
  output logic [AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic rd_en,
  output logic [AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);
  logic aw_take;
  logic w_take;
  logic ar_take;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  assign rd_addr = s_axi_araddr;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SBU_RESP_OKAY;
      wr_en <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      wr_en <= 1'b0;
      if (aw_take) begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      // both halves held, answer once; the write strobe rises with bvalid, the register takes it one edge later
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid && !wr_en) begin
        wr_en <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `SBU_RESP_OKAY : `SBU_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `SBU_RESP_OKAY;
      rd_en <= 1'b0;
    end else begin
      s_axi_arready <= ar_take;
      rd_en <= ar_take && rd_hit;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_hit ? `SBU_RESP_OKAY : `SBU_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: core/sbu_core.sv
// serial bus unit: data register, nack/retry, parity and underrun handling
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "sbu_regs.svh"
// What this block does
// - Flag parity mismatch; broadcast data-field parity error raises status interrupt.
// - Parity error outside data field: abort, status interrupt, back to start wait.
// - Individual data-field parity error: keep receiving, no interrupt, answer NACK.
// - Each transmit byte after the first is requested by the data-set interrupt.
// - Communication start raises status interrupt with error, slave request, arbitration.
// - Slave NACK in data field: resend same byte, no data-set interrupt.
// - Transmit byte missing in time: underrun, error interrupt, communication ends.
// - Master reception: byte to data register, data-set interrupt for DMA.
// - Device NACK in data field: no data-set interrupt, byte received again.
// - Byte still unread when next arrives: answer NACK automatically.
// - Transfer close raises status interrupt telling error, end of comm, end of frame.
module sbu_core
  import sbu_pkg::*;
#(
  parameter int AW = `SBU_ADDR_W,
  parameter int CNT_W = 8,
  parameter bit ODD_PARITY = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register port
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // protocol engine
  input wire sbu_pkg::sbu_lnk_in_t lnk_i,
  output sbu_pkg::sbu_lnk_out_t lnk_o,
  // interrupt and dma request pulses
  output logic data_set_irq,
  output logic comm_status_irq
);
  import sbu_pkg::*;

  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_hit;
  logic rd_en;
  logic [AW-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_hit;

  logic [`SBU_CTRL_W-1:0] ctrl_ff;
  logic [7:0] len_ff;
  logic [7:0] bus_data_reg_ff;
  logic dr_full_ff;
  logic [7:0] tx_byte_ff;
  sbu_stat_t stat_ff;
  sbu_stat_t stat_set;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  sbu_state_t st_ff;
  sbu_lnk_out_t lnk_ff;
  logic dsi_ff;
  logic csi_ff;
  logic rx_late_ff;

  logic pv;
  logic [7:0] pbyte;
  logic pe;
  logic pdf;
  logic pbc;

  logic comm_en;
  logic active;
  logic start_ev;
  logic rx_hdr_err;
  logic rx_bc_err;
  logic rx_ind_nack;
  logic rx_busy_nack;
  logic rx_take;
  logic tx_under;
  logic tx_resend;
  logic tx_fresh;
  logic tx_next_req;
  logic dr_wr;
  logic dr_rd;

  sbu_axil #(
    .AW(AW)
  ) u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );

  sbu_par #(
    .W(8),
    .ODD(ODD_PARITY)
  ) u_par (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(lnk_i.rx_valid),
    .in_byte(lnk_i.rx_byte),
    .in_par(lnk_i.rx_par),
    .in_df(lnk_i.data_field),
    .in_bc(lnk_i.bcast),
    .out_valid(pv),
    .out_byte(pbyte),
    .out_perr(pe),
    .out_df(pdf),
    .out_bc(pbc)
  );

  // address decode
  always_comb begin
    wr_hit = (wr_addr == `SBU_OFS_CTRL) || (wr_addr == `SBU_OFS_STAT) ||
             (wr_addr == `SBU_OFS_DATA) || (wr_addr == `SBU_OFS_LEN);
    rd_hit = wr_hit_rd(rd_addr) || (rd_addr == `SBU_OFS_CNT);
    rd_data = 32'h00000000;
    unique case (rd_addr)
      `SBU_OFS_CTRL: rd_data[`SBU_CTRL_W-1:0] = ctrl_ff;
      `SBU_OFS_STAT: rd_data[7:0] = stat_ff;
      `SBU_OFS_DATA: rd_data[7:0] = bus_data_reg_ff;
      `SBU_OFS_CNT: rd_data[CNT_W-1:0] = cnt_ff;
      `SBU_OFS_LEN: rd_data[7:0] = len_ff;
      default: rd_data = 32'h00000000;
    endcase
  end

  function automatic logic wr_hit_rd(input logic [AW-1:0] a);
    wr_hit_rd = (a == `SBU_OFS_CTRL) || (a == `SBU_OFS_STAT) ||
                (a == `SBU_OFS_DATA) || (a == `SBU_OFS_LEN);
  endfunction

  // event decode
  assign comm_en = ctrl_ff[`SBU_CTRL_COMM_EN];
  assign active = (st_ff != SBU_IDLE);
  assign start_ev = comm_en && lnk_i.comm_start;
  assign rx_hdr_err = active && pv && pe && !pdf;
  assign rx_bc_err = active && pv && pe && pdf && pbc;
  assign rx_ind_nack = active && pv && pe && pdf && !pbc;
  // unread byte blocks the new one; sender repeats it after the nack
  assign rx_busy_nack = active && pv && !pe && pdf && dr_full_ff;
  assign rx_take = active && pv && !pe && pdf && !dr_full_ff;
  assign tx_resend = active && lnk_i.tx_req && (st_ff == SBU_RETRY);
  assign tx_fresh = active && lnk_i.tx_req && (st_ff == SBU_RUN) && dr_full_ff;
  assign tx_under = active && lnk_i.tx_req && (st_ff == SBU_RUN) && !dr_full_ff;
  assign nxt_cnt = cnt_ff + CNT_W'(1);
  // no request after the last byte of the telegram
  assign tx_next_req = active && lnk_i.tx_ack &&
                       (nxt_cnt < CNT_W'(len_ff));
  assign dr_wr = wr_en && (wr_addr == `SBU_OFS_DATA) && wr_strb[0];
  // a byte stored at the edge the read was taken missed that read; keep it full
  assign dr_rd = rd_en && (rd_addr == `SBU_OFS_DATA) && !rx_late_ff;

  // sticky status causes
  always_comb begin
    stat_set = '0;
    stat_set.err = rx_hdr_err || rx_bc_err || tx_under;
    stat_set.parity = rx_hdr_err || rx_bc_err;
    stat_set.underrun = tx_under;
    stat_set.comm_start = start_ev;
    stat_set.slave_req = start_ev && lnk_i.slave_req;
    stat_set.arb_lost = start_ev && lnk_i.arb_lost;
    stat_set.end_comm = active && lnk_i.end_comm;
    stat_set.end_frame = active && lnk_i.end_frame;
  end

  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `SBU_CTRL_RST;
    end else if (wr_en && (wr_addr == `SBU_OFS_CTRL) && wr_strb[0]) begin
      ctrl_ff <= wr_data[`SBU_CTRL_W-1:0];
    end
  end

  // telegram length register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      len_ff <= `SBU_LEN_RST;
    end else if (wr_en && (wr_addr == `SBU_OFS_LEN) && wr_strb[0]) begin
      len_ff <= wr_data[7:0];
    end
  end

  // status: write one to clear, a cause in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= `SBU_STAT_RST;
    end else if (wr_en && (wr_addr == `SBU_OFS_STAT) && wr_strb[0]) begin
      stat_ff <= (stat_ff & ~wr_data[7:0]) | stat_set;
    end else begin
      stat_ff <= stat_ff | stat_set;
    end
  end

  // sequence state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= SBU_IDLE;
    end else if (start_ev) begin
      st_ff <= SBU_RUN;
    end else if (!comm_en || rx_hdr_err || tx_under || lnk_i.end_comm) begin
      st_ff <= SBU_IDLE;
    end else if (active && lnk_i.tx_nack && lnk_i.data_field) begin
      st_ff <= SBU_RETRY;
    end else if (tx_resend) begin
      st_ff <= SBU_RUN;
    end
  end

  // data register: filled by software/dma on send, by the link on receive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_data_reg_ff <= `SBU_DATA_RST;
    end else if (rx_take) begin
      bus_data_reg_ff <= pbyte;
    end else if (dr_wr) begin
      bus_data_reg_ff <= wr_data[7:0];
    end
  end

  // data register occupancy; a fill wins over an empty in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dr_full_ff <= 1'b0;
    end else if (rx_take || dr_wr) begin
      dr_full_ff <= 1'b1;
    end else if (tx_fresh || dr_rd) begin
      dr_full_ff <= 1'b0;
    end
  end

  // store at the edge a read is taken, remembered for the read-clear one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_late_ff <= 1'b0;
    end else begin
      rx_late_ff <= rx_take;
    end
  end

  // byte on the wire is kept so a nack can resend it unchanged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_byte_ff <= 8'h00;
    end else if (tx_fresh) begin
      tx_byte_ff <= bus_data_reg_ff;
    end
  end

  // bytes moved in this communication
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= '0;
    end else if (start_ev) begin
      cnt_ff <= '0;
    end else if (rx_take || (active && lnk_i.tx_ack)) begin
      cnt_ff <= nxt_cnt;
    end
  end

  // answers to the protocol engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lnk_ff <= '0;
      lnk_ff.tel_len <= `SBU_LEN_RST;
    end else begin
      lnk_ff.tx_valid <= tx_fresh || tx_resend;
      lnk_ff.tx_byte <= tx_fresh ? bus_data_reg_ff : tx_byte_ff;
      lnk_ff.rx_ack <= rx_take;
      lnk_ff.rx_nack <= rx_ind_nack || rx_busy_nack;
      lnk_ff.abort <= rx_hdr_err || tx_under;
      lnk_ff.comm_en <= ctrl_ff[`SBU_CTRL_COMM_EN];
      lnk_ff.master_req <= ctrl_ff[`SBU_CTRL_MASTER_REQ];
      lnk_ff.slave_tx_enable_flag <= ctrl_ff[`SBU_CTRL_SLV_TX_EN];
      lnk_ff.slave_rx_en <= ctrl_ff[`SBU_CTRL_SLV_RX_EN];
      lnk_ff.tel_len <= len_ff;
    end
  end
  assign lnk_o = lnk_ff;

  // data-set pulse; nacked or retried bytes never request dma
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dsi_ff <= 1'b0;
    end else begin
      dsi_ff <= rx_take || tx_next_req;
    end
  end

  // status pulse, once per cycle with any new cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csi_ff <= 1'b0;
    end else begin
      csi_ff <= |stat_set;
    end
  end
  assign data_set_irq = dsi_ff;
  assign comm_status_irq = csi_ff;

endmodule

// File: tb/sbu_core_checker.sv
// concurrent checks on the serial bus unit core ports
`timescale 1ns/100ps
module sbu_core_checker
  import sbu_pkg::*;
#(
  parameter bit ODD_PARITY = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // protocol engine
  input wire sbu_pkg::sbu_lnk_in_t lnk_i,
  input wire sbu_pkg::sbu_lnk_out_t lnk_o,
  // interrupt pulses
  input wire logic data_set_irq,
  input wire logic comm_status_irq
);
  logic active_ff;
  logic retry_ff;
  logic [7:0] held_ff;
  logic rx_bad;
  assign rx_bad = lnk_i.rx_par != (^lnk_i.rx_byte ^ ODD_PARITY);
  // busy from start until end, abort or disable
  always_ff @(posedge aclk) begin
    if (!aresetn) active_ff <= 1'b0;
    else if (lnk_i.end_comm || lnk_o.abort || !lnk_o.comm_en) active_ff <= 1'b0;
    else if (lnk_i.comm_start) active_ff <= 1'b1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) held_ff <= 8'h00;
    else if (lnk_o.tx_valid) held_ff <= lnk_o.tx_byte;
  end
  // refused byte pending until it goes out again
  always_ff @(posedge aclk) begin
    if (!aresetn) retry_ff <= 1'b0;
    else if (lnk_o.tx_valid || !active_ff) retry_ff <= 1'b0;
    else if (lnk_i.tx_nack && lnk_i.data_field) retry_ff <= 1'b1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rx_bad;
    active_ff && lnk_i.rx_valid && rx_bad;
  endsequence
  property p_par_ctl;
    s_rx_bad ##0 !lnk_i.data_field |-> ##2 (lnk_o.abort && comm_status_irq);
  endproperty
  a_par_ctl: assert property (p_par_ctl) else $error("header parity not aborted");
  property p_par_ind;
    s_rx_bad ##0 (lnk_i.data_field && !lnk_i.bcast) |-> ##2
      (lnk_o.rx_nack && !comm_status_irq && !data_set_irq && !lnk_o.abort);
  endproperty
  a_par_ind: assert property (p_par_ind) else $error("individual parity not nacked");
  property p_par_bc;
    s_rx_bad ##0 (lnk_i.data_field && lnk_i.bcast) |-> ##2
      (comm_status_irq && !lnk_o.rx_nack && !lnk_o.abort && !data_set_irq);
  endproperty
  a_par_bc: assert property (p_par_bc) else $error("broadcast parity wrong answer");
  property p_nack_quiet;
    active_ff && lnk_i.tx_nack && lnk_i.data_field |-> ##1 !data_set_irq;
  endproperty
  a_nack_quiet: assert property (p_nack_quiet) else $error("data request after nack");
  property p_resend;
    lnk_o.tx_valid && retry_ff |-> lnk_o.tx_byte == held_ff;
  endproperty
  a_resend: assert property (p_resend) else $error("resent byte differs");
  property p_tx_answer;
    active_ff && lnk_i.tx_req |-> ##1 (lnk_o.tx_valid != lnk_o.abort);
  endproperty
  a_tx_answer: assert property (p_tx_answer) else $error("byte request unanswered");
  property p_start;
    lnk_i.comm_start && lnk_o.comm_en |-> ##1 comm_status_irq;
  endproperty
  a_start: assert property (p_start) else $error("no status pulse at start");
  property p_close;
    active_ff && (lnk_i.end_comm || lnk_i.end_frame) |-> ##1 comm_status_irq;
  endproperty
  a_close: assert property (p_close) else $error("no status pulse at close");
  property p_rx_answer;
    active_ff && lnk_i.rx_valid |-> ##2
      ($onehot0({lnk_o.rx_ack, lnk_o.rx_nack, lnk_o.abort}) && (!data_set_irq || lnk_o.rx_ack));
  endproperty
  a_rx_answer: assert property (p_rx_answer) else $error("receive answer clash");
endmodule
bind sbu_core sbu_core_checker #(.ODD_PARITY(ODD_PARITY)) chk_u (
  .aclk(aclk), .aresetn(aresetn), .lnk_i(lnk_i), .lnk_o(lnk_o),
  .data_set_irq(data_set_irq), .comm_status_irq(comm_status_irq)
);

// File: tb/sbu_link_model.sv
// far side model: engine events and remote unit answers
`timescale 1ns/100ps
module sbu_link_model
  import sbu_pkg::*;
(
  // clock
  input wire logic aclk,
  // events towards the core
  output sbu_pkg::sbu_lnk_in_t lnk_i,
  // core answers
  input wire sbu_pkg::sbu_lnk_out_t lnk_o
);
  logic [7:0] last_tx = 8'h00;
  int n_tx = 0;
  initial lnk_i = '0;
  always @(posedge aclk) begin
    if (lnk_o.tx_valid === 1'b1) begin
      last_tx <= lnk_o.tx_byte;
      n_tx <= n_tx + 1;
    end
  end
  // idle byte lines show the inverse, never a stale copy
  task automatic send(input sbu_lnk_in_t v);
    sbu_lnk_in_t q;
    q = '0;
    q.rx_byte = ~v.rx_byte;
    @(posedge aclk);
    lnk_i <= v;
    @(posedge aclk);
    lnk_i <= q;
    repeat (4) @(posedge aclk);
  endtask
  // m: start, byte request, ack, nack, end of comm, end of frame
  task automatic ev(input logic [5:0] m, input logic sreq, input logic arb = 1'b0);
    sbu_lnk_in_t v;
    v = '0;
    {v.comm_start, v.tx_req, v.tx_ack, v.tx_nack, v.end_comm, v.end_frame} = m;
    v.data_field = m[2];
    v.slave_req = sreq;
    v.arb_lost = arb;
    send(v);
  endtask
  task automatic rx(input logic [7:0] b, input logic bad, input logic df, input logic bc);
    sbu_lnk_in_t v;
    v = '0;
    v.rx_valid = 1'b1;
    v.rx_byte = b;
    v.rx_par = ^b ^ bad;
    v.data_field = df;
    v.bcast = bc;
    send(v);
  endtask
endmodule

// File: tb/test_sbu_core.sv
// self-checking bench for the serial bus unit core
`timescale 1ns/100ps
`include "sbu_regs.svh"
module test_sbu_core;
  import sbu_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, dsi, csi;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  sbu_lnk_in_t lnk_i;
  sbu_lnk_out_t lnk_o;
  logic [4:0] ev_now;
  int failures = 0;
  int comparisons = 0;
  int seen[5];
  int want[5];
  initial forever #50 aclk = ~aclk;
  sbu_core dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lnk_i(lnk_i), .lnk_o(lnk_o), .data_set_irq(dsi), .comm_status_irq(csi)
  );
  sbu_link_model part_u (.aclk(aclk), .lnk_i(lnk_i), .lnk_o(lnk_o));
  // pulse tallies: data set, status, ack, nack, abort
  assign ev_now = {dsi, csi, lnk_o.rx_ack, lnk_o.rx_nack, lnk_o.abort};
  always @(posedge aclk) for (int i = 0; i < 5; i++) seen[i] <= seen[i] + ev_now[i];
  task automatic conclude(input bit hung);
    if (hung) failures++;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic ck(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cnts(input logic [4:0] m);
    for (int i = 0; i < 5; i++) begin
      want[i] += m[i];
      ck($sformatf("pulse tally %0d", i), want[i], seen[i]);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er = `SBU_RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    ck("bresp", {30'h0, er}, {30'h0, bresp});
    if (n >= 50) conclude(1);
  endtask
  task automatic rck(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er = `SBU_RESP_OKAY);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    ck("rdata", e, rdata);
    ck("rresp", {30'h0, er}, {30'h0, rresp});
    if (n >= 50) conclude(1);
  endtask
  task automatic ctl(input logic [3:0] e);
    repeat (2) @(posedge aclk);
    ck("ctrl levels", {28'h0, e},
       {28'h0, lnk_o.slave_rx_en, lnk_o.slave_tx_enable_flag, lnk_o.master_req, lnk_o.comm_en});
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rck(`SBU_OFS_CTRL, 32'h0);
    rck(`SBU_OFS_STAT, 32'h0);
    rck(`SBU_OFS_LEN, 32'h20);
    rck(`SBU_OFS_DATA, 32'h0);
    rck(`SBU_OFS_CNT, 32'h0);
    rck(8'h14, 32'h0, `SBU_RESP_SLVERR);
    axw(8'h14, 32'hFF, `SBU_RESP_SLVERR);
    $display("test reset_state ended");
    axw(`SBU_OFS_DATA, 32'hA5);
    axw(`SBU_OFS_LEN, 32'h03);
    axw(`SBU_OFS_CTRL, 32'h0B);
    ctl(4'hB);
    ck("tel_len", 32'h3, {24'h0, lnk_o.tel_len});
    part_u.ev(6'h20, 1'b1);
    cnts(5'b01000);
    rck(`SBU_OFS_STAT, 32'h82);
    part_u.ev(6'h10, 1'b0);
    ck("tx byte", 32'hA5, {24'h0, part_u.last_tx});
    part_u.ev(6'h08, 1'b0);
    cnts(5'b10000);
    axw(`SBU_OFS_DATA, 32'h3C);
    part_u.ev(6'h10, 1'b0);
    part_u.ev(6'h04, 1'b0);
    cnts(5'b00000);
    part_u.ev(6'h10, 1'b0);
    ck("resent byte", 32'h3C, {24'h0, part_u.last_tx});
    ck("tx count", 32'd3, part_u.n_tx);
    part_u.ev(6'h10, 1'b0);
    cnts(5'b01001);
    rck(`SBU_OFS_STAT, 32'hC3);
    rck(`SBU_OFS_CNT, 32'h1);
    axw(`SBU_OFS_STAT, 32'hFF);
    rck(`SBU_OFS_STAT, 32'h0);
    $display("test master_send ended");
    axw(`SBU_OFS_CTRL, 32'h03);
    part_u.ev(6'h20, 1'b0);
    cnts(5'b01000);
    part_u.rx(8'h5A, 1'b0, 1'b1, 1'b0);
    cnts(5'b10100);
    part_u.rx(8'h11, 1'b0, 1'b1, 1'b0);
    cnts(5'b00010);
    rck(`SBU_OFS_DATA, 32'h5A);
    part_u.rx(8'h11, 1'b1, 1'b1, 1'b0);
    cnts(5'b00010);
    part_u.rx(8'h11, 1'b0, 1'b1, 1'b0);
    cnts(5'b10100);
    rck(`SBU_OFS_DATA, 32'h11);
    part_u.ev(6'h01, 1'b0);
    cnts(5'b01000);
    part_u.ev(6'h02, 1'b0);
    cnts(5'b01000);
    rck(`SBU_OFS_STAT, 32'h98);
    rck(`SBU_OFS_CNT, 32'h2);
    axw(`SBU_OFS_STAT, 32'hFF);
    $display("test master_receive ended");
    axw(`SBU_OFS_CTRL, 32'h0D);
    ctl(4'hD);
    part_u.ev(6'h20, 1'b0, 1'b1);
    cnts(5'b01000);
    part_u.rx(8'h66, 1'b1, 1'b1, 1'b1);
    cnts(5'b01000);
    part_u.rx(8'h66, 1'b1, 1'b0, 1'b1);
    cnts(5'b01001);
    part_u.rx(8'h66, 1'b0, 1'b1, 1'b1);
    cnts(5'b00000);
    rck(`SBU_OFS_STAT, 32'hA5);
    $display("test parity_paths ended");
    conclude(0);
  end
endmodule
